/* rtl/cpr_pkg.sv */
// shared constants of the reset and power status block
package cpr_pkg;
	// ****************************************************************
	// pin widths and idle levels
	// ****************************************************************
	localparam int        CPR_REQ_W      = 5;
	localparam int        CPR_RSP_W      = 3;
	localparam int        CPR_STRAP_W    = 4;
	localparam int        CPR_SYNC_DEPTH = 2;
	localparam logic [4:0] CPR_REQ_IDLE_N = 5'h1F;
	localparam logic [2:0] CPR_RSP_IDLE_N = 3'h7;
	localparam logic       CPR_PSI_OFF_N  = 1'h1;
	localparam logic       CPR_STB_IDLE_N = 1'h1;

	// ****************************************************************
	// states, one-hot
	// ****************************************************************
	typedef enum logic [2:0] {
		CPR_ST_RST  = 3'h1,
		CPR_ST_IDLE = 3'h2,
		CPR_ST_REQ  = 3'h4
	} cpr_state_t;
endpackage : cpr_pkg

/* rtl/cpr_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module cpr_sync
	import cpr_pkg::*;
#(
	parameter int W     = 1,
	parameter logic [W-1:0] INIT = '1
)(
	input  wire logic         ref_clk_i, // reference clock
	input  wire logic         rst_i,     // sync reset, active high
	input  wire logic         clk_en_i,  // clock enable
	input  wire logic [W-1:0] d_i,       // asynchronous inputs
	output logic      [W-1:0] q_o        // synchronised outputs
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			meta_reg <= INIT;
			sync_reg <= INIT;
		end
		else if (clk_en_i)
		begin
			meta_reg <= d_i;
			sync_reg <= meta_reg;
		end
	end

	assign q_o = sync_reg;
endmodule : cpr_sync
`default_nettype wire

/* rtl/cpr_top.sv */
// reset, power status and bus command signalling of the processor
`timescale 1ns/10ps
`default_nettype none
module cpr_top
	import cpr_pkg::*;
#(
	parameter int STRAP_W = CPR_STRAP_W
)(
	input  wire logic               ref_clk_i,            // bus clock, 100 MHz
	input  wire logic               rst_i,                // sync reset, active high
	input  wire logic               clk_en_i,             // clock enable
	input  wire logic               reset_n_i,            // processor reset pin
	input  wire logic               supply_ok_i,          // power-good pin
	input  wire logic [STRAP_W-1:0] strap_i,              // configuration straps
	input  wire logic               deep_sleep_i,         // core in Deep Sleep
	input  wire logic               own_bus_i,            // this agent owns the bus
	input  wire logic               req_start_i,          // issue request, pulse
	input  wire logic [4:0]         req_type_i,           // request type, active high
	input  wire logic               rsp_start_i,          // drive response, pulse
	input  wire logic [2:0]         rsp_code_i,           // response code, active high
	input  wire logic [2:0]         response_status_n_i,  // response pins in
	output logic                    power_status_ind_n_o, // power status, active low
	output logic [4:0]              req_cmd_n_o,          // request pins out
	output logic                    req_cmd_oe_o,         // request pins enable
	output logic                    addr_strobe0_n_o,     // address strobe out
	output logic                    addr_strobe0_oe_o,    // address strobe enable
	output logic [2:0]              response_status_n_o,  // response pins out
	output logic                    response_status_oe_o, // response pins enable
	output logic                    rsp_valid_o,          // response received, high while pins not idle
	output logic [2:0]              rsp_status_o,         // received code, active high
	output logic                    core_rst_o,           // core held in reset
	output logic                    cache_inval_o,        // invalidate caches, pulse
	output logic                    cache_wb_en_o,        // write-back allowed
	output logic [STRAP_W-1:0]      strap_o               // captured straps
);
	// ****************************************************************
	// parameter check
	// ****************************************************************
	generate
		if (STRAP_W < 1 || STRAP_W > 32)
		begin : g_bad_strap
			$error("cpr_top: STRAP_W out of range");
		end
	endgenerate

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		cpr_state_t         state;
		logic [4:0]         req_n;
		logic               req_oe;
		logic [2:0]         rsp_n;
		logic               rsp_oe;
		logic               psi_n;
		logic               inval;
		logic [2:0]         rx_code;
		logic               rx_vld;
		logic [STRAP_W-1:0] straps;
	} cpr_regs_t;

	cpr_regs_t          r_reg;
	cpr_regs_t          r_next;
	logic               reset_n_s;
	logic               supply_ok_s;
	logic [2:0]         rsp_in_s;
	logic [STRAP_W-1:0] strap_s;
	logic               rst_act;
	logic               rx_act;

	// any pin not idle means a response is on the wires
	function automatic logic rsp_busy(input logic [2:0] lines_n);
		rsp_busy = (lines_n != CPR_RSP_IDLE_N);
	endfunction : rsp_busy

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	cpr_sync #(
		.W    (STRAP_W + 5),
		.INIT ({{STRAP_W{1'b0}}, 2'h0, CPR_RSP_IDLE_N})
	) u_sync (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.clk_en_i  (clk_en_i),
		.d_i       ({strap_i, reset_n_i, supply_ok_i, response_status_n_i}),
		.q_o       ({strap_s, reset_n_s, supply_ok_s, rsp_in_s})
	);

	// power not good is treated as reset
	assign rst_act = !reset_n_s || !supply_ok_s;
	assign rx_act  = rsp_busy(rsp_in_s) && !rst_act;

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb
	begin
		r_next        = r_reg;
		r_next.inval  = 1'b0;
		r_next.rx_vld = 1'b0;
		r_next.rsp_oe = 1'b0;
		r_next.rsp_n  = CPR_RSP_IDLE_N;
		r_next.psi_n  = !(deep_sleep_i && !rst_act);
		case (r_reg.state)
			CPR_ST_RST:
			begin
				if (!rst_act)
				begin
					r_next.straps = strap_s;
					r_next.state  = CPR_ST_IDLE;
				end
			end
			CPR_ST_IDLE:
			begin
				if (req_start_i && own_bus_i)
				begin
					r_next.req_n  = ~req_type_i;
					r_next.req_oe = 1'b1;
					r_next.state  = CPR_ST_REQ;
				end
			end
			CPR_ST_REQ:
			begin
				r_next.req_n  = CPR_REQ_IDLE_N;
				r_next.req_oe = 1'b0;
				r_next.state  = CPR_ST_IDLE;
			end
			default:
			begin
				r_next.state = CPR_ST_RST;
			end
		endcase
		if (rsp_start_i && !rst_act)
		begin
			r_next.rsp_n  = ~rsp_code_i;
			r_next.rsp_oe = 1'b1;
		end
		if (rx_act)
		begin
			r_next.rx_code = ~rsp_in_s;
			r_next.rx_vld  = 1'b1;
		end
		if (rst_act)
		begin
			r_next.req_n  = CPR_REQ_IDLE_N;
			r_next.req_oe = 1'b0;
			r_next.rsp_n  = CPR_RSP_IDLE_N;
			r_next.rsp_oe = 1'b0;
			r_next.state  = CPR_ST_RST;
			r_next.inval  = (r_reg.state != CPR_ST_RST);
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			r_reg.state   <= CPR_ST_RST;
			r_reg.req_n   <= CPR_REQ_IDLE_N;
			r_reg.req_oe  <= 1'b0;
			r_reg.rsp_n   <= CPR_RSP_IDLE_N;
			r_reg.rsp_oe  <= 1'b0;
			r_reg.psi_n   <= CPR_PSI_OFF_N;
			r_reg.inval   <= 1'b0;
			r_reg.rx_code <= 3'h0;
			r_reg.rx_vld  <= 1'b0;
			r_reg.straps  <= '0;
		end
		else if (clk_en_i)
		begin
			r_reg <= r_next;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign power_status_ind_n_o = r_reg.psi_n;
	assign req_cmd_n_o          = r_reg.req_n;
	assign req_cmd_oe_o         = r_reg.req_oe;
	assign addr_strobe0_n_o     = r_reg.req_oe ? 1'b0 : CPR_STB_IDLE_N;
	assign addr_strobe0_oe_o    = r_reg.req_oe;
	assign response_status_n_o  = r_reg.rsp_n;
	assign response_status_oe_o = r_reg.rsp_oe;
	assign rsp_valid_o          = r_reg.rx_vld;
	assign rsp_status_o         = r_reg.rx_code;
	assign core_rst_o           = (r_reg.state == CPR_ST_RST);
	assign cache_wb_en_o        = (r_reg.state != CPR_ST_RST);
	assign cache_inval_o        = r_reg.inval;
	assign strap_o              = r_reg.straps;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i || !clk_en_i);

	sequence s_req_go;
		req_start_i && own_bus_i && (r_reg.state == CPR_ST_IDLE) && !rst_act;
	endsequence

	sequence s_req_done;
		req_cmd_oe_o && !addr_strobe0_n_o ##1 !req_cmd_oe_o;
	endsequence

	sequence s_rsp_go;
		rsp_start_i && !rst_act;
	endsequence

	a_psi_sleep_low: assert property (
		(deep_sleep_i && !rst_act) |=> !power_status_ind_n_o)
		else $error("status not low in deep sleep");

	a_psi_awake_high: assert property (!deep_sleep_i |=> power_status_ind_n_o)
		else $error("status low while awake");

	a_reset_releases_bus: assert property (
		rst_act |-> ##[1:2] (!req_cmd_oe_o && !addr_strobe0_oe_o && !response_status_oe_o))
		else $error("bus outputs still driven in reset");

	a_reset_core_hold: assert property (rst_act |=> (core_rst_o && !cache_wb_en_o))
		else $error("core not held in reset");

	a_inval_pulse_once: assert property (
		(rst_act && !core_rst_o) ##1 rst_act |-> cache_inval_o ##1 !cache_inval_o)
		else $error("cache invalidate not one pulse");

	a_req_strobe_pair: assert property (
		req_cmd_oe_o |-> (!addr_strobe0_n_o && addr_strobe0_oe_o) ##1 addr_strobe0_n_o)
		else $error("strobe not paired with one command cycle");

	a_req_cmd_issue: assert property (
		s_req_go |=> (req_cmd_n_o == ~$past(req_type_i)) and s_req_done)
		else $error("request command wrong or not one cycle");

	a_rsp_drive_code: assert property (
		s_rsp_go |=> (response_status_oe_o && response_status_n_o == ~$past(rsp_code_i)))
		else $error("response code not driven");

	a_rsp_rx_report: assert property (
		rx_act |=> (rsp_valid_o && rsp_status_o == ~$past(rsp_in_s)))
		else $error("received response not reported");
endmodule : cpr_top
`default_nettype wire

/* bench/cpr_far_model.sv */
// far-side system logic: supplies, reset pin, straps and response agent
`timescale 1ns/10ps
`default_nettype none
module cpr_far_model
	import cpr_pkg::*;
#(
	parameter int                 STRAP_W   = CPR_STRAP_W,
	parameter int                 HOLD_CYC  = 20,
	parameter logic [STRAP_W-1:0] STRAP_VAL = 4'hA
)(
	input  wire logic               ref_clk_i,          // bus clock
	output logic                    supply_ok_o,        // power-good to block
	output logic                    reset_n_o,          // reset pin to block
	output logic [STRAP_W-1:0]      strap_o,            // strap levels
	output logic [2:0]              response_status_n_o // response pins, 7 released
);
	initial
	begin
		supply_ok_o         = 1'h0;
		reset_n_o           = 1'h0;
		strap_o             = ~STRAP_VAL;
		response_status_n_o = 3'h7;
	end

	always @(negedge ref_clk_i)
		if (!reset_n_o || !supply_ok_o)
			response_status_n_o = 3'h7;

	// reset low, clean rise, straps, long hold
	// supply kept high until pin_reset drops it
	task automatic power_up();
		reset_n_o = 1'h0;
		repeat (4) @(negedge ref_clk_i);
		supply_ok_o = 1'h1;
		strap_o     = STRAP_VAL;
		repeat (HOLD_CYC) @(negedge ref_clk_i);
		reset_n_o = 1'h1;
	endtask : power_up

	// drop supply or reset at will
	task automatic pin_reset(input logic by_supply);
		@(negedge ref_clk_i);
		supply_ok_o = ~by_supply;
		reset_n_o   = by_supply;
		strap_o     = ~STRAP_VAL;
	endtask : pin_reset

	task automatic set_rsp(input logic [2:0] code_n);
		response_status_n_o = code_n;
	endtask : set_rsp
endmodule : cpr_far_model
`default_nettype wire

/* bench/cpr_top_tb.sv */
// self-checking bench of the reset and power status block
`timescale 1ns/10ps
`default_nettype none
module cpr_top_tb
	import cpr_pkg::*;
;
	// ****************************************************************
	// stimulus, wiring and instances
	// ****************************************************************
	logic                   ref_clk_i = 1'h0;
	logic                   rst_i = 1'h1;
	logic                   clk_en_i = 1'h1;
	logic                   deep_sleep_i = 1'h0;
	logic                   own_bus_i = 1'h0;
	logic                   req_start_i = 1'h0;
	logic                   rsp_start_i = 1'h0;
	logic [4:0]             req_type_i = 5'h00;
	logic [2:0]             rsp_code_i = 3'h0;
	logic                   supply_ok, reset_n;
	logic [CPR_STRAP_W-1:0] strap, strap_o;
	logic [2:0]             far_rsp_n, rsp_pins, response_status_n_o, rsp_status_o;
	logic [4:0]             req_cmd_n_o;
	logic                   power_status_ind_n_o, req_cmd_oe_o, addr_strobe0_n_o;
	logic                   addr_strobe0_oe_o, response_status_oe_o, rsp_valid_o;
	logic                   core_rst_o, cache_inval_o, cache_wb_en_o;
	int                     fail_count = 0;
	int                     num_checks = 0;
	int                     cycles = 0;

	assign rsp_pins = far_rsp_n & (response_status_oe_o ? response_status_n_o : 3'h7);

	cpr_far_model #(.STRAP_W(CPR_STRAP_W), .HOLD_CYC(20), .STRAP_VAL(4'hA)) far (
		.ref_clk_i(ref_clk_i), .supply_ok_o(supply_ok), .reset_n_o(reset_n),
		.strap_o(strap), .response_status_n_o(far_rsp_n));

	cpr_top #(.STRAP_W(CPR_STRAP_W)) dut (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i), .reset_n_i(reset_n),
		.supply_ok_i(supply_ok), .strap_i(strap), .deep_sleep_i(deep_sleep_i),
		.own_bus_i(own_bus_i), .req_start_i(req_start_i), .req_type_i(req_type_i),
		.rsp_start_i(rsp_start_i), .rsp_code_i(rsp_code_i),
		.response_status_n_i(rsp_pins), .power_status_ind_n_o(power_status_ind_n_o),
		.req_cmd_n_o(req_cmd_n_o), .req_cmd_oe_o(req_cmd_oe_o),
		.addr_strobe0_n_o(addr_strobe0_n_o), .addr_strobe0_oe_o(addr_strobe0_oe_o),
		.response_status_n_o(response_status_n_o),
		.response_status_oe_o(response_status_oe_o), .rsp_valid_o(rsp_valid_o),
		.rsp_status_o(rsp_status_o), .core_rst_o(core_rst_o),
		.cache_inval_o(cache_inval_o), .cache_wb_en_o(cache_wb_en_o), .strap_o(strap_o));

	initial
		forever #5 ref_clk_i = ~ref_clk_i;

	always @(posedge ref_clk_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			fail_count++;
			finish_test();
		end
	end

	// ****************************************************************
	// checks and scenarios
	// ****************************************************************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic power_ready();
		int n;
		n = 0;
		far.power_up();
		while (core_rst_o !== 1'h0 && n < 60)
		begin
			@(negedge ref_clk_i);
			n++;
		end
		chk({core_rst_o, cache_wb_en_o}, 8'h01);
		chk(strap_o, 4'hA);
	endtask : power_ready

	task automatic t_request();
		req_start_i = 1'h1;
		req_type_i  = 5'h03;
		@(negedge ref_clk_i);
		chk(req_cmd_oe_o, 1'h0);
		own_bus_i = 1'h1;
		for (int i = 0; i < 5; i++)
		begin
			req_type_i  = 5'h01 << i;
			req_start_i = 1'h1;
			@(negedge ref_clk_i);
			req_start_i = 1'h0;
			chk({req_cmd_oe_o, addr_strobe0_oe_o, addr_strobe0_n_o}, 3'h6);
			chk(req_cmd_n_o, 5'(~req_type_i));
			@(negedge ref_clk_i);
			chk({req_cmd_oe_o, addr_strobe0_n_o, req_cmd_n_o}, {2'h1, 5'h1F});
		end
		own_bus_i = 1'h0;
	endtask : t_request

	task automatic t_response();
		for (int c = 1; c < 8; c++)
		begin
			rsp_code_i  = 3'(c);
			rsp_start_i = 1'h1;
			@(negedge ref_clk_i);
			chk({response_status_oe_o, response_status_n_o}, {1'h1, ~rsp_code_i});
		end
		rsp_start_i = 1'h0;
		repeat (4) @(negedge ref_clk_i);
		chk({response_status_oe_o, response_status_n_o}, 4'h7);
		for (int c = 1; c < 8; c += 3)
		begin
			far.set_rsp(~3'(c));
			repeat (3) @(negedge ref_clk_i);
			chk({rsp_valid_o, rsp_status_o}, {1'h1, 3'(c)});
			far.set_rsp(3'h7);
			repeat (3) @(negedge ref_clk_i);
			chk(rsp_valid_o, 1'h0);
		end
	endtask : t_response

	task automatic t_sleep();
		deep_sleep_i = 1'h1;
		repeat (2) @(negedge ref_clk_i);
		chk(power_status_ind_n_o, 1'h0);
		deep_sleep_i = 1'h0;
		@(negedge ref_clk_i);
		chk(power_status_ind_n_o, 1'h1);
	endtask : t_sleep

	// clock enable low freezes status and request logic
	task automatic t_freeze();
		clk_en_i     = 1'h0;
		deep_sleep_i = 1'h1;
		own_bus_i    = 1'h1;
		req_type_i   = 5'h0A;
		req_start_i  = 1'h1;
		repeat (3) @(negedge ref_clk_i);
		chk({power_status_ind_n_o, req_cmd_oe_o}, 2'h2);
		req_start_i = 1'h0;
		clk_en_i    = 1'h1;
		@(negedge ref_clk_i);
		chk({power_status_ind_n_o, req_cmd_oe_o}, 2'h0);
		deep_sleep_i = 1'h0;
		own_bus_i    = 1'h0;
		@(negedge ref_clk_i);
		chk(power_status_ind_n_o, 1'h1);
	endtask : t_freeze

	task automatic t_pin_reset(input logic by_supply);
		int seen;
		seen        = 0;
		rsp_code_i  = 3'h2;
		rsp_start_i = 1'h1;
		@(negedge ref_clk_i);
		chk(response_status_oe_o, 1'h1);
		far.pin_reset(by_supply);
		repeat (3)
		begin
			@(negedge ref_clk_i);
			seen = seen + cache_inval_o;
		end
		chk({response_status_oe_o, core_rst_o, cache_wb_en_o}, 3'h2);
		repeat (2)
		begin
			@(negedge ref_clk_i);
			seen = seen + cache_inval_o;
		end
		chk(8'(seen), 8'h01);
		rsp_start_i = 1'h0;
		power_ready();
	endtask : t_pin_reset

	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test

	initial
	begin
		repeat (2) @(negedge ref_clk_i);
		rst_i = 1'h0;
		chk({core_rst_o, cache_wb_en_o, power_status_ind_n_o}, 3'h5);
		power_ready();
		t_request();
		t_response();
		t_sleep();
		t_freeze();
		t_pin_reset(1'h0);
		t_pin_reset(1'h1);
		finish_test();
	end
endmodule : cpr_top_tb
`default_nettype wire
